/* include/msp_pkg.sv */
// msp_pkg: constants, states and carriers of the motor starter process image
// assumes a single 125 MHz clock shared by every file that uses it
package msp_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int unsigned CLK_KHZ = 125_000;
  localparam int unsigned SECOND_MS = 1000;
  localparam int unsigned SEC_CYCLES = SECOND_MS * CLK_KHZ;
  localparam int unsigned DEAD_TIME_MS = 50;
  localparam int unsigned DEAD_CYCLES = DEAD_TIME_MS * CLK_KHZ;
  localparam int unsigned CHECKBACK_MS = 200;
  localparam int unsigned CHECKBACK_CYCLES = CHECKBACK_MS * CLK_KHZ;

  ////////////////////////////////////////////////////////////////////////////
  // ranges and widths
  localparam logic [15:0] CURRENT_MAX_PCT = 16'h0320;
  localparam logic [15:0] THERMAL_MAX_PCT = 16'h0064;
  localparam int unsigned BASE_IN_W = 6;
  localparam int unsigned EXP_IN_W = 8;
  localparam int unsigned EXP_OUT_W = 4;

  ////////////////////////////////////////////////////////////////////////////
  // monitoring byte 0 and byte 1 positions
  localparam int unsigned MON_RUN_REV = 0;
  localparam int unsigned MON_OFF = 1;
  localparam int unsigned MON_RUN_FWD = 2;
  localparam int unsigned MON_OL_WARN = 3;
  localparam int unsigned MON_LOCKOUT = 4;
  localparam int unsigned MON_LOCAL = 5;
  localparam int unsigned MON_FAULT = 6;
  localparam int unsigned MON_WARN = 7;
  localparam int unsigned MON_BASE_LSB = 2;

  ////////////////////////////////////////////////////////////////////////////
  // command byte 0 and byte 1 positions
  localparam int unsigned CMD_RUN_REV = 0;
  localparam int unsigned CMD_OFF = 1;
  localparam int unsigned CMD_RUN_FWD = 2;
  localparam int unsigned CMD_EMERG = 4;
  localparam int unsigned CMD_AUTO = 5;
  localparam int unsigned CMD_RESET = 6;
  localparam int unsigned CMD_AUX_DC = 4;
  localparam int unsigned CMD_RELAY3 = 7;

  ////////////////////////////////////////////////////////////////////////////
  // control states
  typedef enum logic [2:0] {
    ST_IDLE, ST_FWD, ST_REV, ST_STAR, ST_GAP, ST_DELTA
  } msp_state_t;

  // monitoring image, bytes 0 to 15, words in byte order
  typedef struct packed {
    logic [7:0] b0;
    logic [7:0] b1;
    logic [15:0] current;
    logic [15:0] thermal;
    logic [15:0] trip_s;
    logic [15:0] restart_s;
    logic [15:0] word5;
    logic [7:0] b12;
    logic [7:0] b13;
    logic [15:0] word7;
  } msp_mon_t;

  // command image, bytes 0 to 2
  typedef struct packed {
    logic [7:0] b0;
    logic [7:0] b1;
    logic [7:0] b2;
  } msp_cmd_t;

  // analogue values from the overload calculation
  typedef struct packed {
    logic [15:0] current;
    logic [15:0] thermal;
    logic [15:0] trip_s;
    logic [15:0] restart_s;
  } msp_ana_t;

  localparam msp_mon_t MON_RESET = '0;

endpackage : msp_pkg

/* verilog/msp_sec_timer.sv */
// msp_sec_timer: whole-second down counter with its own prescaler
// assumes load comes from logic on ref_clk
`timescale 1ns/1ns
module msp_sec_timer #(
  parameter int unsigned TICK_CYCLES = msp_pkg::SEC_CYCLES,
  parameter int unsigned W = 16
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // load a count of seconds
  input wire logic load,
  input wire logic [W-1:0] load_val,
  // state
  output logic busy,
  output logic [W-1:0] remain_s
);

  logic [31:0] pre_q;
  logic [W-1:0] remain_q;
  logic tick;

  if (TICK_CYCLES < 1 || W < 1 || W > 32) begin : g_bad_param
    $error("msp_sec_timer: unsupported parameters");
  end

  assign tick = (pre_q == 32'(TICK_CYCLES - 1));
  assign busy = (remain_q != '0);
  assign remain_s = remain_q;

  // prescaler restarts on every load so the first second is whole
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pre_q <= 32'h0000_0000;
    end else if (load || !busy || tick) begin
      pre_q <= 32'h0000_0000;
    end else begin
      pre_q <= pre_q + 32'h0000_0001;
    end
  end

  // seconds count down to zero and stop
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      remain_q <= '0;
    end else if (load) begin
      remain_q <= load_val;
    end else if (tick && busy) begin
      remain_q <= remain_q - 1'b1;
    end
  end

endmodule : msp_sec_timer

/* verilog/msp_starter.sv */
// msp_starter: reversing and star-delta control with process image
// assumes command, analogue and config inputs are on ref_clk; pins are not
`timescale 1ns/1ns
module msp_starter #(
  parameter int unsigned SEC_CYCLES = msp_pkg::SEC_CYCLES,
  parameter int unsigned DEAD_CYCLES = msp_pkg::DEAD_CYCLES,
  parameter int unsigned CHECKBACK_CYCLES = msp_pkg::CHECKBACK_CYCLES
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // configuration
  input wire logic mode_sd,
  input wire logic custom_app_en,
  input wire msp_pkg::msp_mon_t custom_mon,
  input wire logic checkback_en,
  input wire logic local_ctrl_en,
  input wire logic relay3_fault_cfg,
  input wire logic aux_dc_fault_cfg,
  input wire logic transition_mode_param,
  input wire logic [15:0] star_phase_time_param,
  input wire logic [15:0] changeover_current_pct,
  input wire logic [15:0] lockout_time_s,
  input wire logic voltage_dip_en,
  // process data from the master and the overload calculation
  input wire msp_pkg::msp_cmd_t cmd,
  input wire msp_pkg::msp_ana_t ana,
  input wire logic fault_in,
  input wire logic warning_in,
  input wire logic overload_warn_in,
  // pins
  input wire logic [msp_pkg::BASE_IN_W-1:0] base_in,
  input wire logic [msp_pkg::EXP_IN_W-1:0] exp_in,
  // outputs
  output msp_pkg::msp_mon_t mon,
  output logic star_relay_output,
  output logic delta_relay_output,
  output logic main_relay_output,
  output logic aux_dc_output,
  output logic [msp_pkg::EXP_OUT_W-1:0] exp_out,
  output logic voltage_dip_avail
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  msp_pkg::msp_state_t state_q, state_d;
  msp_pkg::msp_mon_t mon_q, mon_d;
  logic [msp_pkg::BASE_IN_W-1:0] base_meta_q, base_sync_q;
  logic [msp_pkg::EXP_IN_W-1:0] exp_meta_q, exp_sync_q;
  logic [7:0] cmd_prev_q;
  logic start_prev_q;
  logic last_rev_q, have_run_q, chk_fault_q;
  logic [31:0] dead_q, chk_cnt_q;
  logic star_q, delta_q, main_q, aux_q, dip_q;
  logic [msp_pkg::EXP_OUT_W-1:0] exp_out_q;
  logic auto, fwd_req, rev_req, off_req, reset_req, fault_sum, trip;
  logic start_ok, lock_load, lock_busy, star_load, star_busy, change;
  logic dead_done, sd_run_d, expect_on;
  logic [15:0] lock_remain, star_remain;

  if (SEC_CYCLES < 1 || DEAD_CYCLES < 1 || CHECKBACK_CYCLES < 1)
  begin : g_bad_param
    $error("msp_starter: counts must be at least one cycle");
  end

  // clamp an analogue word to its range
  function automatic logic [15:0] clamp16(input logic [15:0] v,
                                          input logic [15:0] lim);
    clamp16 = (v > lim) ? lim : v;
  endfunction : clamp16

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      base_meta_q <= '0;
      base_sync_q <= '0;
      exp_meta_q <= '0;
      exp_sync_q <= '0;
    end else begin
      base_meta_q <= base_in;
      base_sync_q <= base_meta_q;
      exp_meta_q <= exp_in;
      exp_sync_q <= exp_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // command decode; the master's byte 0 layout is taken as given
  assign auto = cmd.b0[msp_pkg::CMD_AUTO];
  assign reset_req = cmd.b0[msp_pkg::CMD_RESET]
                     & ~cmd_prev_q[msp_pkg::CMD_RESET];
  assign fwd_req = (auto & cmd.b0[msp_pkg::CMD_RUN_FWD]
                    & ~cmd_prev_q[msp_pkg::CMD_RUN_FWD])
                   | (mode_sd & local_ctrl_en & base_sync_q[4]
                      & ~start_prev_q);
  assign rev_req = ~mode_sd & auto & cmd.b0[msp_pkg::CMD_RUN_REV]
                   & ~cmd_prev_q[msp_pkg::CMD_RUN_REV];
  assign off_req = (auto & cmd.b0[msp_pkg::CMD_OFF])
                   | (mode_sd & local_ctrl_en & base_sync_q[5]);
  assign fault_sum = fault_in | chk_fault_q;
  assign trip = fault_sum & ~cmd.b0[msp_pkg::CMD_EMERG];
  assign start_ok = ~off_req & ~trip;

  // edge memory for command bits and local start
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cmd_prev_q <= 8'h00;
      start_prev_q <= 1'b0;
    end else begin
      cmd_prev_q <= cmd.b0;
      start_prev_q <= base_sync_q[4];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // timers: reverse lockout and star phase
  assign lock_load = ((state_q == msp_pkg::ST_FWD)
                      || (state_q == msp_pkg::ST_REV))
                     && (state_d == msp_pkg::ST_IDLE);
  assign star_load = (state_q == msp_pkg::ST_IDLE)
                     && (state_d == msp_pkg::ST_STAR);

  msp_sec_timer #(.TICK_CYCLES(SEC_CYCLES), .W(16)) u_lock_tmr (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .load(lock_load),
    .load_val(lockout_time_s),
    .busy(lock_busy),
    .remain_s(lock_remain)
  );

  msp_sec_timer #(.TICK_CYCLES(SEC_CYCLES), .W(16)) u_star_tmr (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .load(star_load),
    .load_val(star_phase_time_param),
    .busy(star_busy),
    .remain_s(star_remain)
  );

  // changeover on time, or on current falling with time as backstop
  assign change = !star_busy || (transition_mode_param
                  && (ana.current <= changeover_current_pct));
  assign dead_done = (dead_q == 32'(DEAD_CYCLES - 1));

  ////////////////////////////////////////////////////////////////////////////
  // control state machine
  always_comb begin
    state_d = state_q;
    case (state_q)
      msp_pkg::ST_IDLE: begin
        if (start_ok && fwd_req && mode_sd) begin
          state_d = msp_pkg::ST_STAR;
        end else if (start_ok && fwd_req
                     && (!have_run_q || !last_rev_q || !lock_busy)) begin
          state_d = msp_pkg::ST_FWD;
        end else if (start_ok && rev_req
                     && (!have_run_q || last_rev_q || !lock_busy)) begin
          state_d = msp_pkg::ST_REV;
        end
      end
      msp_pkg::ST_FWD, msp_pkg::ST_REV, msp_pkg::ST_DELTA: begin
        if (off_req || trip) begin
          state_d = msp_pkg::ST_IDLE;
        end
      end
      msp_pkg::ST_STAR: begin
        if (off_req || trip) begin
          state_d = msp_pkg::ST_IDLE;
        end else if (change) begin
          state_d = msp_pkg::ST_GAP;
        end
      end
      msp_pkg::ST_GAP: begin
        if (off_req || trip) begin
          state_d = msp_pkg::ST_IDLE;
        end else if (dead_done) begin
          state_d = msp_pkg::ST_DELTA;
        end
      end
      default: state_d = msp_pkg::ST_IDLE;
    endcase
  end

  // state register and direction memory
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= msp_pkg::ST_IDLE;
      last_rev_q <= 1'b0;
      have_run_q <= 1'b0;
    end else begin
      state_q <= state_d;
      if (state_d == msp_pkg::ST_FWD || state_d == msp_pkg::ST_REV) begin
        last_rev_q <= (state_d == msp_pkg::ST_REV);
        have_run_q <= 1'b1;
      end
    end
  end

  // dead interval counter between star and delta
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      dead_q <= 32'h0000_0000;
    end else if (state_q == msp_pkg::ST_GAP) begin
      dead_q <= dead_q + 32'h0000_0001;
    end else begin
      dead_q <= 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // contactor checkback supervision; the set wins over a reset command
  assign expect_on = star_q | delta_q | (mode_sd & main_q);
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      chk_cnt_q <= 32'h0000_0000;
      chk_fault_q <= 1'b0;
    end else begin
      if (checkback_en && (base_sync_q[0] != expect_on)) begin
        chk_cnt_q <= chk_cnt_q + 32'h0000_0001;
      end else begin
        chk_cnt_q <= 32'h0000_0000;
      end
      if (checkback_en && (base_sync_q[0] != expect_on)
          && (chk_cnt_q == 32'(CHECKBACK_CYCLES - 1))) begin
        chk_fault_q <= 1'b1;
      end else if (reset_req) begin
        chk_fault_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // relay and output registers, aligned with the state register
  assign sd_run_d = (state_d == msp_pkg::ST_STAR)
                    || (state_d == msp_pkg::ST_GAP)
                    || (state_d == msp_pkg::ST_DELTA);
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      star_q <= 1'b0;
      delta_q <= 1'b0;
      main_q <= 1'b0;
      aux_q <= 1'b0;
      exp_out_q <= '0;
      dip_q <= 1'b0;
    end else begin
      star_q <= (state_d == msp_pkg::ST_STAR)
                || (state_d == msp_pkg::ST_FWD);
      delta_q <= (state_d == msp_pkg::ST_DELTA)
                 || (state_d == msp_pkg::ST_REV);
      if (mode_sd) begin
        main_q <= sd_run_d;
      end else begin
        main_q <= relay3_fault_cfg ? fault_sum
                                   : cmd.b1[msp_pkg::CMD_RELAY3];
      end
      aux_q <= aux_dc_fault_cfg ? fault_sum
                                : cmd.b1[msp_pkg::CMD_AUX_DC];
      exp_out_q <= cmd.b2[msp_pkg::EXP_OUT_W-1:0];
      dip_q <= voltage_dip_en & ~mode_sd;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // monitoring image
  always_comb begin
    mon_d = msp_pkg::MON_RESET;
    mon_d.b0[msp_pkg::MON_RUN_REV] = ~mode_sd
                                     & (state_q == msp_pkg::ST_REV);
    mon_d.b0[msp_pkg::MON_OFF] = (state_q == msp_pkg::ST_IDLE);
    mon_d.b0[msp_pkg::MON_RUN_FWD] = (state_q == msp_pkg::ST_FWD)
                                     || (state_q == msp_pkg::ST_STAR)
                                     || (state_q == msp_pkg::ST_GAP)
                                     || (state_q == msp_pkg::ST_DELTA);
    mon_d.b0[msp_pkg::MON_OL_WARN] = overload_warn_in;
    mon_d.b0[msp_pkg::MON_LOCKOUT] = ~mode_sd & lock_busy;
    mon_d.b0[msp_pkg::MON_LOCAL] = ~auto;
    mon_d.b0[msp_pkg::MON_FAULT] = fault_sum;
    mon_d.b0[msp_pkg::MON_WARN] = warning_in | overload_warn_in;
    mon_d.b1[msp_pkg::MON_BASE_LSB +: msp_pkg::BASE_IN_W] = base_sync_q;
    mon_d.current = clamp16(ana.current, msp_pkg::CURRENT_MAX_PCT);
    mon_d.thermal = clamp16(ana.thermal, msp_pkg::THERMAL_MAX_PCT);
    mon_d.trip_s = ana.trip_s;
    mon_d.restart_s = ana.restart_s;
    mon_d.b12 = exp_sync_q;
    if (custom_app_en) begin
      mon_d = custom_mon;
    end
  end

  // image register
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      mon_q <= msp_pkg::MON_RESET;
    end else begin
      mon_q <= mon_d;
    end
  end

  assign mon = mon_q;
  assign star_relay_output = star_q;
  assign delta_relay_output = delta_q;
  assign main_relay_output = main_q;
  assign aux_dc_output = aux_q;
  assign exp_out = exp_out_q;
  assign voltage_dip_avail = dip_q;

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  star_delta_excl_a: assert property (
    !(star_relay_output && delta_relay_output))
    else $error("star and delta energised together");

  dead_gap_a: assert property (
    (mode_sd && $rose(delta_relay_output)) |-> !$past(star_relay_output))
    else $error("delta closed without dead interval");

  reverse_block_a: assert property (
    (state_q == msp_pkg::ST_IDLE && have_run_q && !last_rev_q && lock_busy)
    |=> state_q != msp_pkg::ST_REV)
    else $error("reverse start inside lockout");

  same_dir_a: assert property (
    (state_q == msp_pkg::ST_IDLE && !mode_sd && fwd_req && start_ok
     && !last_rev_q) |=> state_q == msp_pkg::ST_FWD)
    else $error("same direction restart refused");

  lockout_bit_a: assert property (
    (lock_load && !mode_sd && lockout_time_s != 16'h0000 && !custom_app_en)
    ##1 !mode_sd && !custom_app_en |=> mon_q.b0[msp_pkg::MON_LOCKOUT])
    else $error("lockout bit not set after stop");

  sd_byte0_a: assert property (
    (mode_sd && !custom_app_en) |=> !mon_q.b0[msp_pkg::MON_RUN_REV]
                                    && !mon_q.b0[msp_pkg::MON_LOCKOUT])
    else $error("reverse bits shown in star-delta");

  relay3_cmd_a: assert property (
    (!mode_sd && !relay3_fault_cfg)
    |=> main_relay_output == $past(cmd.b1[msp_pkg::CMD_RELAY3]))
    else $error("third relay ignores command");

  main_sd_a: assert property (
    (mode_sd && state_q inside {msp_pkg::ST_STAR, msp_pkg::ST_DELTA})
    |-> main_relay_output)
    else $error("main contactor off while running");

  dip_off_a: assert property (
    mode_sd |=> !voltage_dip_avail)
    else $error("voltage dip offered in star-delta");

  current_range_a: assert property (
    !custom_app_en ##1 1'b1 |-> mon_q.current <= msp_pkg::CURRENT_MAX_PCT)
    else $error("current above range");

endmodule : msp_starter

/* verif/msp_master.sv */
// msp_master: fieldbus master model that encodes the command image
// assumes requests come from the bench on ref_clk edges
`timescale 1ns/1ns
module msp_master (
  // requests
  input wire logic run_rev,
  input wire logic off,
  input wire logic run_fwd,
  input wire logic emerg,
  input wire logic auto_mode,
  input wire logic fault_reset,
  input wire logic relay3,
  input wire logic aux_dc,
  input wire logic [3:0] exp_o,
  // command image
  output msp_pkg::msp_cmd_t cmd
);
  // byte 0 layout, bits 3 and 7 unused and held low
  assign cmd.b0 = {1'b0, fault_reset, auto_mode, emerg, 1'b0,
                   run_fwd, off, run_rev};
  // output requests; byte 1 keeps only bits 7 and 4
  assign cmd.b1 = {relay3, 2'b00, aux_dc, 4'h0};
  assign cmd.b2 = {4'h0, exp_o};
endmodule : msp_master

/* verif/msp_starter_test.sv */
// msp_starter_test: directed bench for the starter and its process image
// assumes shortened counts: 10 cycles a second, 3 dead, 20 checkback
`timescale 1ns/1ns
module msp_starter_test;
  logic ref_clk = 0, rst_b = 0, mode_sd = 0, custom_app_en = 0;
  logic checkback_en = 0, local_ctrl_en = 0, relay3_fault_cfg = 0;
  logic aux_dc_fault_cfg = 0, voltage_dip_en = 1, fault_in = 0;
  logic warning_in = 0, rv = 0, of = 0, fw = 0, au = 0, fr = 0;
  logic r3 = 0, ax = 0, gap, em = 0, tm = 0, ow = 0;
  logic [15:0] cc = 16'h0000;
  logic [3:0] eo = 4'h0;
  logic [15:0] star_t = 16'h0001, lock_t = 16'h0002;
  logic [5:0] base_in = 6'h00;
  logic [7:0] exp_in = 8'h00;
  msp_pkg::msp_mon_t custom_mon = '0, mon;
  msp_pkg::msp_ana_t ana = '0;
  msp_pkg::msp_cmd_t cmd;
  logic star, delta, main, aux, dip;
  logic [3:0] exp_out;
  int errors = 0, cmp_count = 0, c;

  ////////////////////////////////////////////////////////////////////////////
  // clock, master model and device
  always #4 ref_clk = ~ref_clk;
  msp_master master (.run_rev(rv), .off(of), .run_fwd(fw), .emerg(em),
    .auto_mode(au), .fault_reset(fr), .relay3(r3), .aux_dc(ax),
    .exp_o(eo), .cmd(cmd));
  msp_starter #(.SEC_CYCLES(10), .DEAD_CYCLES(3), .CHECKBACK_CYCLES(20)) dut (
    .ref_clk(ref_clk), .rst_b(rst_b), .mode_sd(mode_sd),
    .custom_app_en(custom_app_en), .custom_mon(custom_mon),
    .checkback_en(checkback_en), .local_ctrl_en(local_ctrl_en),
    .relay3_fault_cfg(relay3_fault_cfg), .aux_dc_fault_cfg(aux_dc_fault_cfg),
    .transition_mode_param(tm), .star_phase_time_param(star_t),
    .changeover_current_pct(cc), .lockout_time_s(lock_t),
    .voltage_dip_en(voltage_dip_en), .cmd(cmd), .ana(ana),
    .fault_in(fault_in), .warning_in(warning_in), .overload_warn_in(ow),
    .base_in(base_in), .exp_in(exp_in), .mon(mon), .star_relay_output(star),
    .delta_relay_output(delta), .main_relay_output(main),
    .aux_dc_output(aux), .exp_out(exp_out), .voltage_dip_avail(dip));

  ////////////////////////////////////////////////////////////////////////////
  // helpers: edges, settled looks, comparison, verdict
  task tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : tick
  task look(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : look
  task chk(input string nm, input logic [127:0] seen, input logic [127:0] ev);
    cmp_count++;
    if (seen !== ev) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, ev, seen);
    end
  endtask : chk
  task summarize;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : summarize

  // watchdog, well beyond the roughly 160 cycles the tests need
  initial begin
    repeat (5000) @(posedge ref_clk);
    errors++;
    summarize();
  end

  ////////////////////////////////////////////////////////////////////////////
  // test sequence
  initial begin
    tick(3);
    rst_b <= 1'b1;
    tick(1);
    au <= 1'b1;
    look(3);
    chk("idle b0", mon.b0, 8'h02);
    chk("dip rev", dip, 1'b1);
    tick(1);
    fw <= 1'b1;
    look(4);
    chk("fwd relay", star, 1'b1);
    chk("fwd b0", mon.b0, 8'h04);
    tick(1);
    fw <= 1'b0;
    of <= 1'b1;
    look(4);
    chk("off relay", star, 1'b0);
    chk("lockout b0", mon.b0, 8'h12);
    tick(1);
    of <= 1'b0;
    rv <= 1'b1;
    look(4);
    chk("rev refused", delta, 1'b0);
    tick(1);
    rv <= 1'b0;
    fw <= 1'b1;
    look(4);
    chk("same dir", star, 1'b1);
    tick(1);
    fw <= 1'b0;
    of <= 1'b1;
    look(40);
    chk("lockout end", mon.b0, 8'h02);
    tick(1);
    of <= 1'b0;
    rv <= 1'b1;
    look(4);
    chk("rev relay", delta, 1'b1);
    chk("rev b0", mon.b0, 8'h01);
    tick(1);
    rv <= 1'b0;
    of <= 1'b1;
    ana <= {16'h0384, 16'h0096, 16'h0007, 16'h0005};
    exp_in <= 8'h5a;
    base_in <= 6'h2d;
    r3 <= 1'b1;
    ax <= 1'b1;
    eo <= 4'ha;
    look(4);
    $display("reversing test done");
    chk("current", mon.current, 16'h0320);
    chk("thermal", mon.thermal, 16'h0064);
    chk("trip", mon.trip_s, 16'h0007);
    chk("restart", mon.restart_s, 16'h0005);
    chk("exp inputs", mon.b12, 8'h5a);
    chk("base inputs", mon.b1, 8'hb4);
    chk("relay3", main, 1'b1);
    chk("aux", aux, 1'b1);
    chk("exp out", exp_out, 4'ha);
    tick(1);
    relay3_fault_cfg <= 1'b1;
    aux_dc_fault_cfg <= 1'b1;
    look(3);
    chk("relay3 ign", main, 1'b0);
    chk("aux ign", aux, 1'b0);
    tick(1);
    fault_in <= 1'b1;
    warning_in <= 1'b1;
    ow <= 1'b1;
    look(3);
    chk("ol warn", mon.b0[3], 1'b1);
    chk("relay3 flt", main, 1'b1);
    chk("aux flt", aux, 1'b1);
    chk("flt b0", mon.b0[7:6], 2'b11);
    tick(1);
    fault_in <= 1'b0;
    warning_in <= 1'b0;
    ow <= 1'b0;
    mode_sd <= 1'b1;
    base_in <= 6'h2c;
    look(3);
    $display("output mapping test done");
    tick(1);
    of <= 1'b0;
    fw <= 1'b1;
    look(4);
    chk("star", {star, delta, main}, 3'b101);
    chk("sd b0", mon.b0 & 8'h11, 8'h00);
    chk("dip sd", dip, 1'b0);
    gap = 1'b0;
    c = 4;
    while (delta !== 1'b1 && c < 40) begin
      look(1);
      c++;
      chk("overlap", star & delta, 1'b0);
      if (star === 1'b0 && delta === 1'b0 && main === 1'b1)
        gap = 1'b1;
    end
    chk("delta", {star, delta, main}, 3'b011);
    chk("dead gap", gap, 1'b1);
    chk("star time", c >= 12, 1'b1);
    tick(1);
    checkback_en <= 1'b1;
    look(30);
    chk("checkback", mon.b0[6], 1'b1);
    tick(1);
    fw <= 1'b0;
    of <= 1'b1;
    checkback_en <= 1'b0;
    fr <= 1'b1;
    tick(2);
    fr <= 1'b0;
    of <= 1'b0;
    au <= 1'b0;
    local_ctrl_en <= 1'b1;
    base_in <= 6'h00;
    look(4);
    chk("local b0", mon.b0[6:5], 2'b01);
    tick(1);
    base_in <= 6'h10;
    look(6);
    chk("local start", star, 1'b1);
    tick(1);
    base_in <= 6'h20;
    look(6);
    chk("local stop", {star, delta, main}, 3'b000);
    $display("star-delta test done");
    tick(1);
    custom_mon <= 128'h0123_4567_89ab_cdef_fedc_ba98_7654_3210;
    custom_app_en <= 1'b1;
    look(3);
    chk("custom", mon, 128'h0123_4567_89ab_cdef_fedc_ba98_7654_3210);
    $display("custom image test done");
    summarize();
  end
endmodule : msp_starter_test
